// File: uiavu_top.sv
// usb interrupt sources, merge, autovector substitution, two-wire request
// assumes processor side strobes are one-cycle pulses in the core clock
// assumes enable and clear inputs follow the usb source index order
`timescale 1ns/1ps
`include "uiavu_consts.svh"
module uiavu_top #(
    parameter int SUSPEND_CYC = `UIAVU_SUSPEND_CYC,
    parameter int NEP         = 16
) (
    input  wire logic                      I_CLK,              // core clock
    input  wire logic                      I_RST_N,            // sync reset
    input  wire logic                      i_setup_token,      // setup decoded pulse
    input  wire logic                      i_setup_data_ok,    // 8 bytes stored pulse
    input  wire logic                      i_sof,              // sof received pulse
    input  wire logic [`UIAVU_FRAME_W-1:0] i_frame_num,        // frame number with sof
    input  wire logic                      i_bus_active,       // any bus activity
    input  wire logic                      i_se0,              // d+ and d- both low
    input  wire logic [NEP-1:0]            i_ep_busy,          // {out7..0,in7..0} busy
    input  wire logic [NEP-1:0]            i_ep_clr,           // write-one clear ep bits
    input  wire logic [4:0]                i_usb_clr,          // write-one clear usb bits
    input  wire logic [`UIAVU_NSRC-1:0]    i_src_en,           // per source enables
    input  wire logic                      i_vector_substitute_en, // substitution on
    input  wire logic                      i_int_taken,        // processor took usb int
    input  wire logic                      i_fetch,            // program fetch strobe
    input  wire logic [15:0]               i_fetch_addr,       // fetch address
    input  wire logic [7:0]                i_fetch_data,       // program byte
    input  wire logic                      i_tw_done,          // two-wire byte done
    input  wire logic                      i_tw_access,        // access to tw regs
    input  wire logic                      i_tw_enable,        // ext_int_enable bit 1
    input  wire logic                      i_tw_flag_wr0,      // zero written to flag
    output logic                           o_usb_int_line,     // usb interrupt pulse
    output logic [7:0]                     o_vector_byte,      // current vector byte
    output logic [7:0]                     o_fetch_data,       // byte to processor
    output logic [4:0]                     o_usb_req,          // usb request bits
    output logic [NEP-1:0]                 o_ep_req,           // endpoint request bits
    output logic [7:0]                     o_frame_number_hi,  // frame number high
    output logic [7:0]                     o_frame_number_lo,  // frame number low
    output logic                           o_tw_done,          // two-wire done flag
    output logic                           o_ext_int_flag5,    // two-wire pending
    output logic                           o_twowire_int_line  // two-wire interrupt
);
    localparam int NS = `UIAVU_NSRC;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [NS-1:0]                 req;
        logic [NEP-1:0]                busy_d;
        logic                          se0_d;
        logic [31:0]                   idle_cnt;
        logic                          suspend_irq_done;
        logic [`UIAVU_FRAME_W-1:0]     frame;
        logic                          pulse;
        logic [7:0]                    vec;
        logic [7:0]                    fdata;
        uiavu_pkg::uiavu_vstate_t      vst;
        logic                          tw_done;
        logic                          tw_pend;
        logic                          tw_line;
    } uiavu_state_t;

    uiavu_state_t st_reg;
    uiavu_state_t st_next;

    logic          any;
    logic [7:0]    code;
    logic [NS-1:0] pend_en;
    logic [NS-1:0] clr_all;
    logic [NS-1:0] set_all;
    logic [NEP-1:0] ep_fall;
    logic [NS-1:0] prio_req;
    logic          vec_fetch;

    // ------------------------------------------------------------
    // request merge and priority order
    // ------------------------------------------------------------
    assign pend_en   = st_reg.req & i_src_en;
    assign clr_all   = {i_ep_clr, i_usb_clr};
    assign vec_fetch = i_fetch && (i_fetch_addr == `UIAVU_VEC_ADDR);
    // usb sources keep their place; endpoints interleave in then out
    assign prio_req[`UIAVU_SRC_EP_BASE-1:0] = pend_en[`UIAVU_SRC_EP_BASE-1:0];

    uiavu_prio #(
        .NSRC (NS)
    ) u_prio (
        .i_req  (prio_req),
        .o_any  (any),
        .o_code (code)
    );

    // ------------------------------------------------------------
    // endpoint busy edge detect
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NEP; g++) begin : g_ep
            assign ep_fall[g] = st_reg.busy_d[g] & ~i_ep_busy[g];
            // in g takes slot 2g, out g takes slot 2g+1, after the usb five
            if (g < NEP / 2) begin : g_in
                assign prio_req[`UIAVU_SRC_EP_BASE + 2 * g] = pend_en[`UIAVU_SRC_EP_BASE + g];
            end else begin : g_out
                assign prio_req[`UIAVU_SRC_EP_BASE + 2 * (g - NEP / 2) + 1] =
                    pend_en[`UIAVU_SRC_EP_BASE + g];
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;

        // ------------------------------------------------------------
        // request set and clear
        // ------------------------------------------------------------
        set_all = '0;
        set_all[`UIAVU_SRC_SUDATA]   = i_setup_data_ok;
        set_all[`UIAVU_SRC_FRAME]    = i_sof;
        set_all[`UIAVU_SRC_SUTOKEN]  = i_setup_token;
        set_all[`UIAVU_SRC_SUSPEND]  = ~st_reg.suspend_irq_done
            && (st_reg.idle_cnt == 32'(SUSPEND_CYC - 1)) && !i_bus_active;
        set_all[`UIAVU_SRC_BUSRESET] = i_se0 & ~st_reg.se0_d;
        set_all[NS-1:`UIAVU_SRC_EP_BASE] = ep_fall;
        st_next.busy_d = i_ep_busy;
        st_next.se0_d  = i_se0;
        // set beats clear
        st_next.req = (st_reg.req & ~clr_all) | set_all;

        // ------------------------------------------------------------
        // suspend idle timer
        // ------------------------------------------------------------
        if (i_bus_active) begin
            st_next.idle_cnt  = '0;
            st_next.suspend_irq_done = 1'b0;
        end else if (st_reg.idle_cnt != 32'(SUSPEND_CYC - 1)) begin
            st_next.idle_cnt = st_reg.idle_cnt + 32'h1;
        end else begin
            st_next.suspend_irq_done = 1'b1;
        end

        // ------------------------------------------------------------
        // frame number
        // ------------------------------------------------------------
        if (i_sof) begin
            st_next.frame = i_frame_num;
        end

        // ------------------------------------------------------------
        // interrupt pulse
        // ------------------------------------------------------------
        // pulse on new enabled request or after a clear with others left
        st_next.pulse = |(set_all & i_src_en)
            | (|(clr_all & st_reg.req) & |(pend_en & ~clr_all));

        // ------------------------------------------------------------
        // vector capture and substitution
        // ------------------------------------------------------------
        st_next.fdata = i_fetch_data;
        unique case (st_reg.vst)
            uiavu_pkg::UIAVU_IDLE: begin
                st_next.vec = any ? code : 8'h00;
                if (i_int_taken) begin
                    st_next.vst = uiavu_pkg::UIAVU_HELD;
                end
            end
            uiavu_pkg::UIAVU_HELD: begin
                if (vec_fetch) begin
                    st_next.vst = uiavu_pkg::UIAVU_IDLE;
                end
            end
            default: begin
                st_next.vst = uiavu_pkg::UIAVU_IDLE;
            end
        endcase
        if (i_vector_substitute_en && vec_fetch) begin
            st_next.fdata = (st_reg.vst == uiavu_pkg::UIAVU_HELD) ? st_reg.vec : code;
        end

        // ------------------------------------------------------------
        // two-wire request
        // ------------------------------------------------------------
        if (i_tw_done) begin
            st_next.tw_done = 1'b1;
        end else if (i_tw_access) begin
            st_next.tw_done = 1'b0;
        end
        if (i_tw_done) begin
            st_next.tw_pend = 1'b1;
        end else if (i_tw_access || i_tw_flag_wr0) begin
            st_next.tw_pend = 1'b0;
        end
        st_next.tw_line = st_next.tw_pend & i_tw_enable;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            st_reg     <= '0;
            st_reg.vst <= uiavu_pkg::UIAVU_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_usb_int_line     = st_reg.pulse;
    assign o_vector_byte      = st_reg.vec;
    assign o_fetch_data       = st_reg.fdata;
    assign o_usb_req          = st_reg.req[4:0];
    assign o_ep_req           = st_reg.req[NS-1:`UIAVU_SRC_EP_BASE];
    assign o_frame_number_hi  = {5'h00, st_reg.frame[10:8]};
    assign o_frame_number_lo  = st_reg.frame[7:0];
    assign o_tw_done          = st_reg.tw_done;
    assign o_ext_int_flag5    = st_reg.tw_pend;
    assign o_twowire_int_line = st_reg.tw_line;
endmodule

// File: uiavu_consts.svh
// constants for the usb interrupt and autovector unit
// assumes inclusion by bare name; definitions only
//
// Contract
// - setup token decode raises setup token request
// - eight clean setup bytes raise data request
// - frame number stored, then frame request set
// - three ms idle bus raises suspend
// - bus reset onset raises reset request
// - sixteen endpoint requests; out means data resident
// - in request means buffer freed by host
// - endpoint busy falling edge sets its request
// - twenty-one sources merge onto one usb line
// - enabled substitution replaces byte at 0x0045
// - vector byte step four, low bits zero
// - fixed codes 00 to 10 for five sources
// - two-wire done sets flag and request latch
// - two-wire enable bit, flag cleared writing zero
// - two-wire register access clears pending request
// - write one clears; pending re-pulses usb line
// - lower index wins; setup data highest
`ifndef UIAVU_CONSTS_SVH
`define UIAVU_CONSTS_SVH

`define UIAVU_NSRC          21
`define UIAVU_SRC_SUDATA    0
`define UIAVU_SRC_FRAME     1
`define UIAVU_SRC_SUTOKEN   2
`define UIAVU_SRC_SUSPEND   3
`define UIAVU_SRC_BUSRESET  4
`define UIAVU_SRC_EP_BASE   5
`define UIAVU_EP_CODE_BASE  8'h18
`define UIAVU_VEC_ADDR      16'h0045
`define UIAVU_SUSPEND_NS    3000000
`define UIAVU_CLK_NS        8
`define UIAVU_SUSPEND_CYC   ((`UIAVU_SUSPEND_NS) / (`UIAVU_CLK_NS))
`define UIAVU_FRAME_W       11

`endif

// File: uiavu_pkg.sv
// types for the usb interrupt and autovector unit
// assumes uiavu_consts.svh is compiled alongside
package uiavu_pkg;
    typedef enum logic [1:0] {
        UIAVU_IDLE,
        UIAVU_ARMED,
        UIAVU_HELD
    } uiavu_vstate_t;
endpackage

// File: uiavu_prio.sv
// priority encoder: lowest set index wins, gives vector code
// assumes 21 request lines, index 0 highest priority
`timescale 1ns/1ps
`include "uiavu_consts.svh"
module uiavu_prio #(
    parameter int NSRC = `UIAVU_NSRC
) (
    input  wire logic [NSRC-1:0] i_req,   // enabled pending requests
    output logic                 o_any,   // any request present
    output logic [7:0]           o_code   // vector byte for winner
);
    logic [4:0] idx;
    always_comb begin
        idx = 5'h00;
        for (int k = NSRC - 1; k >= 0; k--) begin
            if (i_req[k]) begin
                idx = 5'(k);
            end
        end
    end
    assign o_any = |i_req;
    assign o_code = (idx < 5'(`UIAVU_SRC_EP_BASE)) ? {1'b0, idx, 2'b00}
                  : 8'(`UIAVU_EP_CODE_BASE + {1'b0, idx - 5'(`UIAVU_SRC_EP_BASE), 2'b00});
endmodule

// File: uiavu_top_sva.sv
// checker: request, vector and two-wire timing of uiavu_top
// assumes bind onto uiavu_top, one clock domain
`timescale 1ns/1ps
module uiavu_top_sva #(
    parameter int NEP = 16
) (
    input wire logic           I_CLK,             // clock
    input wire logic           I_RST_N,           // reset
    input wire logic           i_setup_token,     // token
    input wire logic           i_setup_data_ok,   // data ok
    input wire logic           i_sof,             // sof
    input wire logic [10:0]    i_frame_num,       // frame
    input wire logic [NEP-1:0] i_ep_busy,         // busy
    input wire logic           i_int_taken,       // take
    input wire logic           i_fetch,           // fetch
    input wire logic [15:0]    i_fetch_addr,      // address
    input wire logic           i_vector_substitute_en, // subst
    input wire logic           i_tw_done,         // tw done
    input wire logic           o_usb_int_line,    // pulse
    input wire logic [7:0]     o_vector_byte,     // vector
    input wire logic [7:0]     o_fetch_data,      // fetched
    input wire logic [4:0]     o_usb_req,         // usb bits
    input wire logic [NEP-1:0] o_ep_req,          // ep bits
    input wire logic [7:0]     o_frame_number_hi, // frame hi
    input wire logic [7:0]     o_frame_number_lo, // frame lo
    input wire logic           o_ext_int_flag5,   // tw flag
    input wire logic           i_se0,             // se0 level
    input wire logic           i_tw_access,       // tw access
    input wire logic [NEP+4:0] i_src_en,          // enables
    input wire logic [NEP-1:0] i_ep_clr,          // ep clears
    input wire logic [4:0]     i_usb_clr          // usb clears
);
    logic [NEP-1:0] busy_q;
    logic [NEP+4:0] clr_w;
    logic [NEP+4:0] req_w;
    logic [NEP-1:0] ep_fell;
    logic           vfetch;
    logic           hold_q;
    assign ep_fell = busy_q & ~i_ep_busy;
    assign vfetch  = i_fetch && i_fetch_addr == 16'h0045;
    assign clr_w   = {i_ep_clr, i_usb_clr};
    assign req_w   = {o_ep_req, o_usb_req};
    always_ff @(posedge I_CLK) begin
        busy_q <= i_ep_busy;
        hold_q <= I_RST_N && (i_int_taken || (hold_q && !vfetch));
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    a_token_sets_bit: assert property (i_setup_token |=> o_usb_req[2])
        else $error("setup token bit not set");
    a_data_sets_bit: assert property (i_setup_data_ok |=> o_usb_req[0])
        else $error("setup data bit not set");
    a_frame_stored: assert property (i_sof |=> o_usb_req[1] &&
        {o_frame_number_hi, o_frame_number_lo} == {5'h00, $past(i_frame_num)})
        else $error("frame number wrong");
    a_busy_fall_sets: assert property (|ep_fell |=>
        (o_ep_req & $past(ep_fell)) == $past(ep_fell)) else $error("ep bit not set");
    a_pulse_has_src: assert property (o_usb_int_line |-> |{o_ep_req, o_usb_req})
        else $error("pulse without request");
    a_vector_subst: assert property (vfetch && i_vector_substitute_en |=>
        o_fetch_data == $past(o_vector_byte)) else $error("vector not substituted");
    a_vector_held: assert property (hold_q && $past(hold_q) |-> $stable(o_vector_byte))
        else $error("vector moved before fetch");
    a_tw_done_flag: assert property (i_tw_done |=> o_ext_int_flag5)
        else $error("two-wire flag not set");
    a_se0_sets_bit: assert property ($rose(i_se0) |=> o_usb_req[4])
        else $error("bus reset bit not set");
    a_clear_repulse: assert property (|(clr_w & req_w) && |(req_w & i_src_en & ~clr_w)
        |=> o_usb_int_line) else $error("no pulse after clear");
    a_tw_access_clr: assert property (i_tw_access && !i_tw_done |=> !o_ext_int_flag5)
        else $error("two-wire request not cleared");
endmodule
bind uiavu_top uiavu_top_sva #(.NEP(NEP)) chk (.*);

// File: uiavu_cpu_model.sv
// processor model: takes usb interrupts, jumps via the vector, clears the bit
// assumes all strobes move at the falling edge of the core clock
`timescale 1ns/1ps
module uiavu_cpu_model (
    input  wire logic        i_clk,      // clock
    input  wire logic        i_go,       // service on
    input  wire logic        i_int_line, // usb pulse
    input  wire logic [7:0]  i_fetch_q,  // fetched byte
    output logic             o_taken,    // take strobe
    output logic             o_fetch,    // fetch strobe
    output logic [15:0]      o_addr,     // address
    output logic [7:0]       o_pdata,    // program byte
    output logic [20:0]      o_clr,      // clears
    output logic [23:0]      o_log       // vectors seen
);
    // request slot of a vector code: usb five, then the eight in, then the eight out
    function automatic int slot(input logic [7:0] c);
        return c < 8'h18 ? int'(c[4:2]) : 5 + (c / 4 - 6) / 2 + 8 * ((c / 4 - 6) % 2);
    endfunction
    assign o_pdata = o_addr[1:0] == 2'b11 ? 8'h02 : (o_addr[0] ? 8'h00 : 8'h04);
    initial begin
        {o_taken, o_fetch, o_addr, o_clr, o_log} = '0;
        forever begin
            @(negedge i_clk) o_clr = '0;
            if (i_go && i_int_line) begin
                o_taken = 1;
                @(negedge i_clk) {o_taken, o_fetch, o_addr} = {2'b01, 16'h0043};
                @(negedge i_clk) o_addr = 16'h0044;
                @(negedge i_clk) o_addr = 16'h0045;
                @(negedge i_clk) o_fetch = 0;
                o_log = {o_log[15:0], i_fetch_q};
                o_clr[slot(i_fetch_q)] = 1;
            end
        end
    end
endmodule

// File: usb_irq_autovector_unit_bench.sv
// self-checking bench for uiavu_top with the processor model
// assumes suspend count shortened to SC cycles
`timescale 1ns/1ps
module usb_irq_autovector_unit_bench;
    localparam int SC = 20;
    logic        clk = 0, rst_n = 0, tok = 0, dok = 0, sof = 0, act = 1, se0 = 0;
    logic        twd = 0, twa = 0, twe = 0, tww = 0, go = 0, avn = 1;
    logic [10:0] fn = '0;
    logic [15:0] busy = '0;
    logic [20:0] en = '1, call = '0, mclr;
    logic [23:0] log_q;
    logic [15:0] addr, ereq;
    logic [7:0]  pdata, vec, fdat, fhi, flo;
    logic [4:0]  ureq;
    logic        taken, fetch, int_l, twdone, flag5, twline;
    int          fails = 0;
    int          total_checks = 0;
    uiavu_top #(.SUSPEND_CYC(SC)) dut (.I_CLK(clk), .I_RST_N(rst_n), .i_setup_token(tok),
        .i_setup_data_ok(dok), .i_sof(sof), .i_frame_num(fn), .i_bus_active(act),
        .i_se0(se0), .i_ep_busy(busy), .i_ep_clr(mclr[20:5] | call[20:5]),
        .i_usb_clr(mclr[4:0] | call[4:0]), .i_src_en(en), .i_vector_substitute_en(avn),
        .i_int_taken(taken), .i_fetch(fetch), .i_fetch_addr(addr), .i_fetch_data(pdata),
        .i_tw_done(twd), .i_tw_access(twa), .i_tw_enable(twe), .i_tw_flag_wr0(tww),
        .o_usb_int_line(int_l), .o_vector_byte(vec), .o_fetch_data(fdat), .o_usb_req(ureq),
        .o_ep_req(ereq), .o_frame_number_hi(fhi), .o_frame_number_lo(flo),
        .o_tw_done(twdone), .o_ext_int_flag5(flag5), .o_twowire_int_line(twline));
    uiavu_cpu_model cpu (.i_clk(clk), .i_go(go), .i_int_line(int_l), .i_fetch_q(fdat),
        .o_taken(taken), .o_fetch(fetch), .o_addr(addr), .o_pdata(pdata), .o_clr(mclr),
        .o_log(log_q));
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        @(negedge clk) s = 0;
    endtask
    task t_usb_events;
        fn = 11'h5A3;
        pulse(sof);
        chk({fhi, flo}, 16'h05A3);
        chk({int_l, ureq}, 6'h22);
        pulse(tok);
        chk(ureq, 5'h06);
        pulse(dok);
        chk(ureq, 5'h07);
        se0 = 1;
        @(negedge clk) chk(ureq, 5'h17);
        {se0, act} = 2'b00;
        repeat (SC - 1) @(negedge clk);
        chk(ureq[3], 1'b0);
        @(negedge clk) chk(ureq[3], 1'b1);
        act = 1;
    endtask
    task t_endpoints;
        en = '0;
        for (int i = 0; i < 16; i++) begin
            busy[i] = 1;
            @(negedge clk) chk(ereq, (24'h1 << i) - 1);
            busy[i] = 0;
            @(negedge clk) chk({int_l, ereq}, (24'h2 << i) - 1);
        end
    endtask
    task t_vector_map;
        for (int i = 0; i < 21; i++) begin
            en = 21'h1 << i;
            @(negedge clk) chk(vec, i < 5 ? i * 4
                : (i < 13 ? 24 + (i - 5) * 8 : 28 + (i - 13) * 8));
        end
        en = '1;
        call = '1;
        @(negedge clk) call = '0;
    endtask
    task t_service;
        busy[2] = 1;
        busy[8] = 1;
        @(negedge clk) go = 1;
        busy = '0;
        pulse(dok);
        for (int k = 0; k < 200 && {ureq, ereq} !== '0; k++) @(negedge clk);
        chk(log_q, 24'h001C28);
        chk({ureq, ereq}, 24'h0);
        go = 0;
    endtask
    task t_plain_fetch;
        {avn, go} = 2'b01;
        pulse(sof);
        repeat (6) @(negedge clk);
        chk({log_q[7:0], ureq}, 13'h0002);
        {call, go} = {21'h2, 1'b0};
        @(negedge clk) {call, avn} = {21'h0, 1'b1};
    endtask
    task t_twowire;
        pulse(twd);
        chk({twdone, flag5, twline}, 3'b110);
        twe = 1;
        @(negedge clk) chk(twline, 1'b1);
        pulse(twa);
        chk({flag5, twline}, 2'b00);
        pulse(twd);
        pulse(tww);
        chk({flag5, twline}, 2'b00);
    endtask
    task report_and_stop;
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial forever #4 clk = ~clk;
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1;
        @(negedge clk);
        t_usb_events;
        t_endpoints;
        t_vector_map;
        t_service;
        t_plain_fetch;
        t_twowire;
        report_and_stop;
    end
    initial begin
        #20000;
        fails++;
        report_and_stop;
    end
endmodule
